// ---- inc/ladder_pkg.sv ----
// Purpose: shared constants, states and carriers for the ladder address initialisation block
// Assumes: one 250 MHz clock, serial link pins sampled through synchronisers
// Notes: register layout is the 16-bit chain position address word
`default_nettype none
package ladder_pkg;
   localparam int CLOCK_MHZ = 250;
   localparam logic [1:0] ASSIGN_TOP = 2'b11;         // top bits of the first address assign byte
   localparam logic [1:0] LOW_FIXED = 2'b10;          // bits 7:6 of the address word low byte
   localparam logic [7:0] POSITION_REG_IDX = 8'h01;   // offset of chain_position_address
   localparam logic [6:0] GROUP_ADDR_RST = 7'h40;     // group bus address after power-up
   localparam logic [15:0] POSITION_RST = 16'h0080;   // address word before any assignment
   localparam int FINAL_LSB = 8;                      // final_device_address position in the word
   localparam int FINAL_W = 5;
   localparam int OWN_LSB = 1;                        // own address position in the word
   localparam logic [3:0] BYTE_BITS = 4'h8;
   localparam logic [1:0] IDX_ADDR = 2'h0;
   localparam logic [1:0] IDX_REG = 2'h1;
   localparam logic [1:0] IDX_UPPER = 2'h2;
   localparam logic [1:0] IDX_TAIL = 2'h3;

   typedef enum logic [2:0] {
      PH_IDLE = 3'b000,
      PH_RX = 3'b001,
      PH_ACK = 3'b010,
      PH_TX = 3'b011,
      PH_TXACK = 3'b100,
      PH_IGNORE = 3'b101
   } phase_e;

   // raw link pins as they arrive
   typedef struct packed {
      logic scl;
      logic sda;
   } link_in_s;

   // group bus address reprogramming request
   typedef struct packed {
      logic wr;
      logic [6:0] val;
   } group_cfg_s;
endpackage
`default_nettype wire

// ---- logic/ladder_address_init.sv ----
// Purpose: address initialisation slave of one device in a daisy-chained monitoring ladder
// Assumes: host master on the serial link; scl/sda are asynchronous and are synchronised here
// Notes: sda is open drain, driven low only; the word is returned low byte first
//
// Overview of operation
// - assign byte has ones in bits 7:6, zero in bit 0, address between, LSB first.
// - on the assign byte the device loads the carried five-bit address.
// - on enumeration the device returns both bytes of its address word at offset one.
// - group bus address is forty hex after power-up.
// - group bus address may change only after the first full initialisation.
// - own address sits in bits five down to one of the low byte, LSB first.
`default_nettype none
module ladder_address_init (
   input wire logic clock,
   input wire logic rst_b,
   input wire ladder_pkg::link_in_s link_in,
   input wire ladder_pkg::group_cfg_s group_cfg,
   output logic sda_o,
   output logic sda_oe,
   output logic [15:0] position_addr,
   output logic address_assigned,
   output logic chain_initialized,
   output logic [6:0] group_addr
);
   import ladder_pkg::*;

   typedef struct packed {
      logic scl_s1;
      logic scl_s2;
      logic scl_s3;
      logic sda_s1;
      logic sda_s2;
      logic sda_s3;
      phase_e phase;
      logic [3:0] bit_cnt;
      logic [7:0] shift;
      logic [1:0] byte_idx;
      logic rd;
      logic hold;
      logic tx_hi;
      logic acked;
      logic assigned;
      logic init_done;
      logic [7:0] reg_ptr;
      logic [6:0] group_addr;
      logic [15:0] addr_reg;
      logic sda_oe;
   } state_s;

   state_s q;
   state_s d;
   logic rise;
   logic fall;
   logic start;
   logic stop;
   logic byte_end;

   // first address assign pattern, shared by the datapath and its checks
   function automatic logic is_assign(input logic [7:0] b);
      return (b[7:6] == ASSIGN_TOP) && !b[0];
   endfunction

   // link events come only from the second and third sync stages
   assign rise = q.scl_s2 & ~q.scl_s3;
   assign fall = ~q.scl_s2 & q.scl_s3;
   assign start = q.scl_s2 & q.scl_s3 & ~q.sda_s2 & q.sda_s3;
   assign stop = q.scl_s2 & q.scl_s3 & q.sda_s2 & ~q.sda_s3;
   assign byte_end = (q.phase == PH_RX) && fall && (q.bit_cnt == BYTE_BITS);

   // next-state logic for the whole block
   always_comb begin
      d = q;
      d.scl_s1 = link_in.scl;
      d.scl_s2 = q.scl_s1;
      d.scl_s3 = q.scl_s2;
      d.sda_s1 = link_in.sda;
      d.sda_s2 = q.sda_s1;
      d.sda_s3 = q.sda_s2;
      // reprogramming before the chain is up would split the ladder's group address
      if (group_cfg.wr && q.init_done) begin
         d.group_addr = group_cfg.val;
      end
      if (start) begin
         d.phase = PH_RX;
         d.bit_cnt = '0;
         d.byte_idx = IDX_ADDR;
         d.rd = 1'b0;
         d.hold = 1'b0;
         d.sda_oe = 1'b0;
      end else if (stop) begin
         d.phase = PH_IDLE;
         d.sda_oe = 1'b0;
      end else begin
         unique case (q.phase)
            PH_IDLE, PH_IGNORE: begin
            end
            PH_RX: begin
               if (rise) begin
                  d.shift = {q.shift[6:0], q.sda_s2};
                  d.bit_cnt = q.bit_cnt + 4'h1;
               end else if (byte_end) begin
                  d.bit_cnt = '0;
                  d.phase = PH_IGNORE; // no acknowledge unless a case below claims the byte
                  unique case (q.byte_idx)
                     IDX_ADDR: begin
                        if (is_assign(q.shift)) begin
                           d.addr_reg[7:0] = {LOW_FIXED, q.shift[5:1], 1'b0};
                           d.assigned = 1'b1;
                           d.hold = 1'b1;
                           d.phase = PH_ACK;
                        end else if (q.assigned && q.shift[7:1] == q.group_addr &&
                                     (!q.shift[0] || q.reg_ptr == POSITION_REG_IDX)) begin
                           d.rd = q.shift[0];
                           d.byte_idx = IDX_REG;
                           d.phase = PH_ACK;
                        end
                     end
                     IDX_REG: begin
                        d.reg_ptr = q.shift;
                        d.byte_idx = IDX_UPPER;
                        if (q.shift == POSITION_REG_IDX) begin
                           d.phase = PH_ACK;
                        end
                     end
                     IDX_UPPER: begin
                        // upper byte carries the final device address of the chain
                        d.addr_reg[15:8] = {3'b000, q.shift[FINAL_W-1:0]};
                        d.init_done = 1'b1;
                        d.byte_idx = IDX_TAIL;
                        d.phase = PH_ACK;
                     end
                     IDX_TAIL: begin
                        d.phase = PH_ACK; // low byte is don't care, check byte not verified
                     end
                  endcase
                  d.sda_oe = (d.phase == PH_ACK);
               end
            end
            PH_ACK: begin
               if (fall) begin
                  d.sda_oe = 1'b0;
                  if (q.rd) begin
                     // enumeration read: low byte first, then upper
                     d.phase = PH_TX;
                     d.tx_hi = 1'b0;
                     d.shift = q.addr_reg[7:0];
                     d.sda_oe = ~q.addr_reg[7];
                  end else begin
                     d.phase = q.hold ? PH_IGNORE : PH_RX;
                  end
               end
            end
            PH_TX: begin
               if (rise) begin
                  d.bit_cnt = q.bit_cnt + 4'h1;
               end else if (fall) begin
                  if (q.bit_cnt == BYTE_BITS) begin
                     d.bit_cnt = '0;
                     d.sda_oe = 1'b0;
                     d.phase = PH_TXACK;
                  end else begin
                     d.shift = {q.shift[6:0], 1'b0};
                     d.sda_oe = ~q.shift[6];
                  end
               end
            end
            PH_TXACK: begin
               if (rise) begin
                  d.acked = ~q.sda_s2;
               end else if (fall) begin
                  if (q.acked && !q.tx_hi) begin
                     d.tx_hi = 1'b1;
                     d.shift = q.addr_reg[15:8];
                     d.sda_oe = ~q.addr_reg[15];
                     d.phase = PH_TX;
                  end else begin
                     d.phase = PH_IGNORE; // host nack, or the end of the upper byte, ends the read
                  end
               end
            end
            default: begin
               d.phase = PH_IDLE;
            end
         endcase
      end
   end

   // single state register; sync stages restart idle-high on reset
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         q <= '0;
         q.scl_s1 <= 1'b1;
         q.scl_s2 <= 1'b1;
         q.scl_s3 <= 1'b1;
         q.sda_s1 <= 1'b1;
         q.sda_s2 <= 1'b1;
         q.sda_s3 <= 1'b1;
         q.phase <= PH_IDLE;
         q.group_addr <= GROUP_ADDR_RST;
         q.addr_reg <= POSITION_RST;
      end else begin
         q <= d;
      end
   end

   // outputs straight from the state register, except sda_o which is tied low
   assign sda_o = 1'b0;
   assign sda_oe = q.sda_oe;
   assign position_addr = q.addr_reg;
   assign address_assigned = q.assigned;
   assign chain_initialized = q.init_done;
   assign group_addr = q.group_addr;

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_b);

   AST_ASSIGN_LOAD: assert property (byte_end && q.byte_idx == IDX_ADDR && is_assign(q.shift) |=>
      q.addr_reg[5:1] == $past(q.shift[5:1]) && q.assigned && q.sda_oe)
      else $error("assign byte did not load the address");
   AST_LOW_FORM: assert property (q.assigned |->
      q.addr_reg[7:6] == LOW_FIXED && !q.addr_reg[0])
      else $error("low byte of address word malformed");
   AST_ASSIGN_ACK: assert property (byte_end && is_assign(q.shift) && q.byte_idx == IDX_ADDR |=>
      q.phase == PH_ACK && q.sda_oe)
      else $error("assign byte not acknowledged");
   AST_ENUM_FIRST_BIT: assert property (q.phase == PH_TX && $past(q.phase) == PH_ACK |->
      q.sda_oe == ~q.addr_reg[7] && !q.tx_hi)
      else $error("enumeration reply does not start with low byte");
   AST_GROUP_DEFAULT: assert property (!q.init_done |-> q.group_addr == GROUP_ADDR_RST)
      else $error("group address left its default before initialisation");
   AST_GROUP_WRITE: assert property (group_cfg.wr && q.init_done |=>
      q.group_addr == $past(group_cfg.val))
      else $error("group address reprogramming lost");
   AST_UNASSIGNED_IGNORE: assert property (byte_end && q.byte_idx == IDX_ADDR && !q.assigned &&
      !is_assign(q.shift) |=> q.phase == PH_IGNORE && !q.sda_oe [*2])
      else $error("unassigned device answered a command");
endmodule
`default_nettype wire

// ---- sim/ladder_host.sv ----
// Purpose: behavioural host master that initialises the ladder over the serial link
// Assumes: the wire level is resolved outside; a released line pulls up
// Notes: each bit's scl phase lasts ten clocks, start and stop highs twenty, above the eight the slave needs
`default_nettype none
module ladder_host (
   input wire logic clock,
   input wire logic sda,
   output logic scl,
   output logic sda_low
);
   timeunit 1ns;
   timeprecision 100ps;
   import ladder_pkg::*;
   // idle bus at time zero
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   // every pin change happens on a rising edge, then holds for n clocks
   task automatic drv(input logic s, input logic l, input int n);
      scl <= s;
      sda_low <= l;
      repeat (n) @(posedge clock);
   endtask
   // data moves only in the low phase; read late in the high phase when settled
   task automatic bit_x(input logic b, output logic r);
      drv(1'b0, sda_low, 5);
      drv(1'b0, ~b, 5);
      drv(1'b1, ~b, 9);
      #1 r = sda;
      @(posedge clock);
   endtask
   task automatic start_c;
      drv(1'b0, sda_low, 5);
      drv(1'b0, 1'b0, 5);
      drv(1'b1, 1'b0, 10);
      drv(1'b1, 1'b1, 10);
   endtask
   task automatic stop_c;
      drv(1'b0, sda_low, 5);
      drv(1'b0, 1'b1, 5);
      drv(1'b1, 1'b1, 10);
      drv(1'b1, 1'b0, 10);
   endtask
   task automatic wbyte(input logic [7:0] b, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_x(b[i], r);
      bit_x(1'b1, r);
      ack = ~r;
   endtask
   // last high sends a nack so the slave lets go of the line
   task automatic rbyte(input logic last, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
      bit_x(last, r);
   endtask
   // address travels lsb first between the fixed top ones and low zero
   task automatic assign_cmd(input logic [4:0] a, output logic ack);
      start_c;
      wbyte({ASSIGN_TOP, a[0], a[1], a[2], a[3], a[4], 1'b0}, ack);
      stop_c;
   endtask
   // three bytes to the first device, then the word comes back low byte first
   task automatic enum_cmd(input logic [6:0] g, output logic [15:0] w, output logic ack);
      logic a1, a2, a3;
      start_c;
      wbyte({g, 1'b0}, a1);
      wbyte(POSITION_REG_IDX, a2);
      start_c;
      wbyte({g, 1'b1}, a3);
      rbyte(1'b0, w[7:0]);
      rbyte(1'b1, w[15:8]);
      stop_c;
      ack = a1 & a2 & a3;
   endtask
   // sent once enumeration is over, and once before any assignment to check it is refused; the low byte and check byte are filler
   task automatic dist_cmd(input logic [6:0] g, input logic [4:0] la, output logic ack);
      logic a1, a2, a3, a4, a5;
      start_c;
      wbyte({g, 1'b0}, a1);
      wbyte(POSITION_REG_IDX, a2);
      wbyte({3'b000, la}, a3);
      // the filler bytes are acknowledged too, so their answers count as well
      wbyte(8'h00, a4);
      wbyte(8'h00, a5);
      stop_c;
      ack = a1 & a2 & a3 & a4 & a5;
   endtask
endmodule
`default_nettype wire

// ---- sim/tb_top.sv ----
// Purpose: self-checking bench for the ladder address initialisation slave
// Assumes: the host model is the only master; the wire pulls up when released
// Notes: a single device, so the final address equals its own
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   import ladder_pkg::*;
   logic clock = 1'b0;
   logic rst_b = 1'b0;
   group_cfg_s group_cfg;
   link_in_s link_in;
   logic sda_o, sda_oe, address_assigned, chain_initialized, h_scl, h_low;
   logic [15:0] position_addr;
   logic [6:0] group_addr;
   int n_errors = 0;
   int samples_checked = 0;
   int seed = 59832;
   // open drain: either party pulling low wins
   assign link_in = '{scl: h_scl, sda: ~(h_low | sda_oe)};
   ladder_address_init dut (.clock(clock), .rst_b(rst_b), .link_in(link_in), .group_cfg(group_cfg),
      .sda_o(sda_o), .sda_oe(sda_oe), .position_addr(position_addr), .address_assigned(address_assigned),
      .chain_initialized(chain_initialized), .group_addr(group_addr));
   ladder_host host (.clock(clock), .sda(link_in.sda), .scl(h_scl), .sda_low(h_low));
   initial begin
      forever #2 clock = ~clock;
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic final_report;
      $display("checks %0d errors %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // own address reversed into bits 5:1, final address in the upper byte
   function automatic logic [15:0] exp_word(input logic [4:0] a, input logic [4:0] la);
      return {3'b000, la, LOW_FIXED, a[0], a[1], a[2], a[3], a[4], 1'b0};
   endfunction
   task automatic set_group(input logic [6:0] v);
      group_cfg <= '{wr: 1'b1, val: v};
      @(posedge clock);
      group_cfg.wr <= 1'b0;
      repeat (3) @(posedge clock);
   endtask
   // hang guard: the whole run needs roughly ten thousand clocks
   initial begin
      repeat (60000) @(posedge clock);
      n_errors++;
      final_report;
   end
   initial begin
      logic [15:0] w;
      logic ack;
      logic [4:0] a, n;
      logic [6:0] g;
      group_cfg = '0;
      repeat (10) @(posedge clock);
      rst_b <= 1'b1;
      repeat (5) @(posedge clock);
      chk(position_addr, POSITION_RST);
      chk({9'h000, group_addr}, 16'h0040);
      host.enum_cmd(GROUP_ADDR_RST, w, ack);
      chk({14'h0000, ack, address_assigned}, 16'h0000);
      host.dist_cmd(GROUP_ADDR_RST, 5'h03, ack);
      chk({14'h0000, ack, chain_initialized}, 16'h0000);
      set_group(7'h15);
      chk({9'h000, group_addr}, 16'h0040);
      $display("test locks_before_init done");
      repeat (3) begin
         a = 5'($random(seed));
         host.assign_cmd(a, ack);
         chk({14'h0000, ack, address_assigned}, 16'h0003);
         chk(position_addr, exp_word(a, 5'h00));
         host.enum_cmd(GROUP_ADDR_RST, w, ack);
         chk(w, exp_word(a, 5'h00));
         chk({15'h0000, ack}, 16'h0001);
      end
      // bit 0 set spoils the assign pattern, and a wrong register byte is refused
      host.start_c;
      host.wbyte(8'hC1, ack);
      host.stop_c;
      chk(position_addr, exp_word(a, 5'h00));
      chk({15'h0000, ack}, 16'h0000);
      host.start_c;
      host.wbyte({GROUP_ADDR_RST, 1'b0}, ack);
      host.wbyte(8'h02, ack);
      host.stop_c;
      chk({15'h0000, ack}, 16'h0000);
      // the pointer now holds a refused register, so a bare read must be refused
      host.start_c;
      host.wbyte({GROUP_ADDR_RST, 1'b1}, ack);
      host.stop_c;
      chk({15'h0000, ack}, 16'h0000);
      $display("test assign_and_enumerate done");
      host.dist_cmd(GROUP_ADDR_RST, a, ack);
      chk(position_addr, exp_word(a, a));
      chk({14'h0000, ack, chain_initialized}, 16'h0003);
      host.enum_cmd(GROUP_ADDR_RST, w, ack);
      n = w[12:8] - {w[1], w[2], w[3], w[4], w[5]} + 5'h01;
      chk({5'h00, ack, w[12:8], n}, {5'h00, 1'b1, a, 5'h01});
      g = {1'b0, 6'($random(seed))};
      set_group(g);
      chk({9'h000, group_addr}, {9'h000, g});
      host.enum_cmd(g, w, ack);
      chk(w, exp_word(a, a));
      chk({15'h0000, ack}, 16'h0001);
      $display("test final_and_group done");
      // a second reset mid-run must bring back every power-up value, bus idle meanwhile
      rst_b <= 1'b0;
      repeat (2) @(posedge clock);
      rst_b <= 1'b1;
      repeat (5) @(posedge clock);
      chk(position_addr, POSITION_RST);
      chk({5'h00, group_addr, sda_o, sda_oe, address_assigned, chain_initialized}, {5'h00, GROUP_ADDR_RST, 4'h0});
      $display("test reset_restart done");
      final_report;
   end
endmodule
`default_nettype wire
